// ===== logic/dual_rail_sequencer_supervisor.sv
// sequencer and supervisor for a boost rail and a buck rail
`timescale 1ns/10ps
module dual_rail_sequencer_supervisor #(
	parameter int DEGLITCH_CYCLES = seq_pkg::DEGLITCH_CYCLES,
	parameter int COOLOFF_CYCLES = seq_pkg::COOLOFF_CYCLES,
	parameter int BLINK_PERIOD_CYCLES = seq_pkg::BLINK_PERIOD_CYCLES,
	parameter int BLINK_ON_CYCLES = seq_pkg::BLINK_ON_CYCLES
)(
	input wire logic core_clk, // system clock, 100 MHz
	input wire logic srst, // synchronous reset, active high
	input wire logic enable_pin, // converter enable, active high
	input wire logic battery_start_ok, // battery above start threshold
	input wire logic battery_fault_low, // battery below fault threshold
	input wire logic battery_low_warn, // battery below low threshold
	input wire logic boost_feedback_sense, // boost rail at nominal
	input wire logic buck_feedback_sense, // buck rail at nominal
	output logic boost_rail_enable, // run boost converter
	output logic buck_rail_enable, // run buck converter
	output logic battery_input_connect, // boost input switch closed
	output logic boost_rail_discharge, // boost output pull-down on
	output logic buck_rail_discharge, // buck output pull-down on
	output logic supply_ok_output_out, // open-drain level, always low
	output logic supply_ok_output_oe, // high while pulling low
	output logic indicator_out, // open-drain level, always low
	output logic indicator_oe // high while lamp is lit
);
	localparam int DEG_LAST_I = DEGLITCH_CYCLES - 1;
	localparam int COOL_LAST_I = COOLOFF_CYCLES - 1;
	localparam int TRIP_I = seq_pkg::FAULT_LIMIT + 1;
	// deglitch and cool-off last counts and the fault trip count
	localparam logic [seq_pkg::CNT_W-1:0] DEG_LAST =
		DEG_LAST_I[seq_pkg::CNT_W-1:0];
	localparam logic [seq_pkg::CNT_W-1:0] COOL_LAST =
		COOL_LAST_I[seq_pkg::CNT_W-1:0];
	localparam logic [seq_pkg::FAULT_W-1:0] TRIP_CNT =
		TRIP_I[seq_pkg::FAULT_W-1:0];

	seq_pkg::seq_reg_t cur;
	seq_pkg::seq_reg_t next_cur;
	logic en;
	logic start_ok;
	logic bat_low;
	logic warn;
	logic fb1;
	logic fb2;
	logic sense_bad;
	logic fault_trip;
	logic pg_drop;
	logic powering;

	blink_if bl();

	blink_timer #(
		.PERIOD_CYCLES(BLINK_PERIOD_CYCLES),
		.ON_CYCLES(BLINK_ON_CYCLES)
	) u_blink (
		.core_clk(core_clk),
		.srst(srst),
		.bl(bl.timer)
	);

	assign en = cur.pin_sync[seq_pkg::IDX_EN];
	assign start_ok = cur.pin_sync[seq_pkg::IDX_START];
	assign bat_low = cur.pin_sync[seq_pkg::IDX_FAULT];
	assign warn = cur.pin_sync[seq_pkg::IDX_WARN];
	assign fb1 = cur.pin_sync[seq_pkg::IDX_FB1];
	assign fb2 = cur.pin_sync[seq_pkg::IDX_FB2];
	assign sense_bad = bat_low || !fb1 || !fb2;
	assign fault_trip = cur.fault_cnt == TRIP_CNT;
	assign pg_drop = cur.state == seq_pkg::ST_RUN && sense_bad &&
		cur.deglitch == DEG_LAST;

	always_comb
	begin
		next_cur = cur;
		powering = 1'b0;
		next_cur.od_level = seq_pkg::OD_LEVEL;
		// two-stage synchroniser for all pins
		next_cur.pin_meta = {buck_feedback_sense, boost_feedback_sense,
			battery_low_warn, battery_fault_low, battery_start_ok,
			enable_pin};
		next_cur.pin_sync = cur.pin_meta;

		// cool-off cycle count while battery sits below fault level
		if (!en || cur.state == seq_pkg::ST_OFF)
		begin
			next_cur.cooloff = '0;
			next_cur.fault_cnt = '0;
		end
		else if (!bat_low)
		begin
			next_cur.cooloff = '0;
			next_cur.fault_cnt = '0;
		end
		else if (cur.cooloff == COOL_LAST)
		begin
			next_cur.cooloff = '0;
			if (!fault_trip)
				next_cur.fault_cnt = cur.fault_cnt + 1'b1;
		end
		else
		begin
			next_cur.cooloff = cur.cooloff + 1'b1;
		end

		// deglitch of a low sense while running
		if (cur.state == seq_pkg::ST_RUN && sense_bad)
		begin
			if (cur.deglitch != DEG_LAST)
				next_cur.deglitch = cur.deglitch + 1'b1;
		end
		else
		begin
			next_cur.deglitch = '0;
		end

		if (!en)
		begin
			next_cur.state = seq_pkg::ST_OFF;
		end
		else if (fault_trip && cur.state != seq_pkg::ST_OFF)
		begin
			next_cur.state = seq_pkg::ST_FAULT_OFF;
		end
		else
		begin
			case (cur.state)
				seq_pkg::ST_OFF:
					next_cur.state = seq_pkg::ST_WAIT_BATT;
				seq_pkg::ST_WAIT_BATT:
					if (start_ok)
						next_cur.state = seq_pkg::ST_BOOST_UP;
				seq_pkg::ST_BOOST_UP:
					if (fb1)
						next_cur.state = seq_pkg::ST_BUCK_UP;
				seq_pkg::ST_BUCK_UP:
					if (fb2)
						next_cur.state = seq_pkg::ST_RUN;
				seq_pkg::ST_RUN:
					if (pg_drop)
						next_cur.state = seq_pkg::ST_WAIT_BATT;
				seq_pkg::ST_FAULT_OFF:
					next_cur.state = seq_pkg::ST_FAULT_OFF;
				default:
					next_cur.state = seq_pkg::ST_OFF;
			endcase
		end

		case (next_cur.state)
			seq_pkg::ST_BOOST_UP,
			seq_pkg::ST_BUCK_UP,
			seq_pkg::ST_RUN:
				powering = 1'b1;
			default:
				powering = 1'b0;
		endcase
		// both rails drop together and the input switch opens
		next_cur.boost_en = powering;
		next_cur.boost_connect = powering;
		next_cur.buck_en = next_cur.state == seq_pkg::ST_BUCK_UP ||
			next_cur.state == seq_pkg::ST_RUN;
		next_cur.boost_dis = !powering;
		next_cur.buck_dis = !powering;
		// supply-ok released only when the sequence is done
		next_cur.pg_pull = next_cur.state != seq_pkg::ST_RUN;

		// indicator: steady, blinking or dark
		next_cur.blink_run = en && warn &&
			next_cur.state != seq_pkg::ST_FAULT_OFF;
		if (!en || next_cur.state == seq_pkg::ST_FAULT_OFF)
			next_cur.lamp_on = 1'b0;
		else if (!warn)
			next_cur.lamp_on = 1'b1;
		else
			next_cur.lamp_on = bl.lamp;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			cur <= seq_pkg::SEQ_RESET;
		else
			cur <= next_cur;
	end

	assign bl.run = cur.blink_run;
	assign boost_rail_enable = cur.boost_en;
	assign buck_rail_enable = cur.buck_en;
	assign battery_input_connect = cur.boost_connect;
	assign boost_rail_discharge = cur.boost_dis;
	assign buck_rail_discharge = cur.buck_dis;
	assign supply_ok_output_out = cur.od_level;
	assign supply_ok_output_oe = cur.pg_pull;
	assign indicator_out = cur.od_level;
	assign indicator_oe = cur.lamp_on;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence waiting_no_battery;
		en && cur.state == seq_pkg::ST_WAIT_BATT && !start_ok;
	endsequence

	sequence enable_dropped;
		en ##1 !en;
	endsequence

	sequence sense_bad_held;
		cur.state == seq_pkg::ST_RUN && sense_bad &&
			cur.deglitch == DEG_LAST;
	endsequence

	start_gated_a: assert property (
		waiting_no_battery |=> cur.state != seq_pkg::ST_BOOST_UP)
		else $error("power-up began without start threshold");
	boost_before_buck_a: assert property (
		buck_rail_enable |-> boost_rail_enable)
		else $error("buck rail enabled without boost rail");
	buck_waits_boost_a: assert property (
		$rose(buck_rail_enable) |-> $past(fb1) && $past(boost_rail_enable))
		else $error("buck rail enabled before boost rail was up");
	fault_shutdown_a: assert property (
		en && fault_trip |=> !boost_rail_enable && !buck_rail_enable &&
			boost_rail_discharge && buck_rail_discharge)
		else $error("battery fault did not shut both rails down");
	enable_off_a: assert property (
		enable_dropped |=> !boost_rail_enable && !buck_rail_enable &&
			!battery_input_connect)
		else $error("enable low did not disconnect the rails");
	shutdown_discharge_a: assert property (
		!en |=> (boost_rail_discharge && buck_rail_discharge) [*2])
		else $error("outputs not discharged after enable low");
	off_rail_discharge_a: assert property (
		!boost_rail_enable |-> boost_rail_discharge && buck_rail_discharge)
		else $error("rails off while discharge is released");
	pg_deglitch_a: assert property (
		sense_bad_held |=> supply_ok_output_oe)
		else $error("supply-ok not pulled low after deglitch");
	pg_glitch_held_a: assert property (
		cur.state == seq_pkg::ST_RUN && en && !fault_trip &&
			sense_bad && cur.deglitch == '0 |=> !supply_ok_output_oe)
		else $error("supply-ok dropped before deglitch expired");
	pg_enable_low_a: assert property (
		!en |=> supply_ok_output_oe)
		else $error("supply-ok not pulled low at once on enable low");
	lamp_steady_a: assert property (
		en && !warn && !fault_trip &&
			cur.state != seq_pkg::ST_FAULT_OFF |=> indicator_oe)
		else $error("indicator not lit with battery normal");
	lamp_blink_a: assert property (
		en && warn && !fault_trip && cur.state != seq_pkg::ST_FAULT_OFF
			|=> indicator_oe == $past(bl.lamp))
		else $error("indicator does not follow the blink timer");
	lamp_dark_a: assert property (
		!en || cur.state == seq_pkg::ST_FAULT_OFF |=> !indicator_oe)
		else $error("indicator lit while disabled or tripped");
	fault_count_clear_a: assert property (
		en && !bat_low |=> cur.fault_cnt == '0)
		else $error("cool-off count kept after battery recovered");

	// one full cool-off cycle spent below the fault level
	sequence cooloff_wrap;
		en && bat_low && cur.state != seq_pkg::ST_OFF &&
			cur.cooloff == COOL_LAST && !fault_trip;
	endsequence

	cooloff_step_a: assert property (
		cooloff_wrap |=> cur.fault_cnt == $past(cur.fault_cnt) + 1'b1)
		else $error("cool-off cycle not counted");
	fault_latched_a: assert property (
		en && cur.state == seq_pkg::ST_FAULT_OFF |=>
			cur.state == seq_pkg::ST_FAULT_OFF)
		else $error("battery fault shutdown left while enabled");
	rails_drop_together_a: assert property (
		$fell(boost_rail_enable) |-> !buck_rail_enable)
		else $error("buck rail still on after boost rail dropped");
	restart_from_off_a: assert property (
		en && cur.state == seq_pkg::ST_OFF |=>
			cur.state == seq_pkg::ST_WAIT_BATT)
		else $error("enable high did not start the sequence");
	boost_first_a: assert property (
		$rose(boost_rail_enable) |-> !buck_rail_enable)
		else $error("buck rail on before boost rail came up");
	connect_follows_a: assert property (
		battery_input_connect == boost_rail_enable)
		else $error("boost input switch out of step with boost rail");
	pg_only_in_run_a: assert property (
		!supply_ok_output_oe |-> boost_rail_enable && buck_rail_enable)
		else $error("supply-ok released with a rail off");
	pg_restart_a: assert property (
		en && !fault_trip && pg_drop |=> !boost_rail_enable &&
			boost_rail_discharge && buck_rail_discharge &&
			supply_ok_output_oe)
		else $error("supply-ok drop did not discharge the rails");
endmodule : dual_rail_sequencer_supervisor

// ===== logic/seq_pkg.sv
// shared constants and state types for the dual rail sequencer
package seq_pkg;
	localparam int CLK_MHZ = 100;
	localparam int BLINK_PERIOD_MS = 4000;
	localparam int BLINK_DUTY_PCT = 25;
	localparam int BLINK_PERIOD_CYCLES = BLINK_PERIOD_MS * CLK_MHZ * 1000;
	localparam int BLINK_ON_CYCLES =
		BLINK_PERIOD_CYCLES / 100 * BLINK_DUTY_PCT;
	localparam int BLINK_W = 29;
	localparam int DEGLITCH_CYCLES = 16;
	localparam int COOLOFF_CYCLES = 64;
	localparam int CNT_W = 16;
	localparam int FAULT_LIMIT = 15;
	localparam int FAULT_W = 5;
	localparam int PIN_W = 6;
	localparam int IDX_EN = 0;
	localparam int IDX_START = 1;
	localparam int IDX_FAULT = 2;
	localparam int IDX_WARN = 3;
	localparam int IDX_FB1 = 4;
	localparam int IDX_FB2 = 5;
	localparam logic OD_LEVEL = 1'b0;

	typedef enum logic [2:0]
	{
		ST_OFF,
		ST_WAIT_BATT,
		ST_BOOST_UP,
		ST_BUCK_UP,
		ST_RUN,
		ST_FAULT_OFF
	} seq_state_t;

	typedef struct packed
	{
		logic [PIN_W-1:0] pin_meta;
		logic [PIN_W-1:0] pin_sync;
		seq_state_t state;
		logic [CNT_W-1:0] deglitch;
		logic [CNT_W-1:0] cooloff;
		logic [FAULT_W-1:0] fault_cnt;
		logic pg_pull;
		logic boost_en;
		logic buck_en;
		logic boost_connect;
		logic boost_dis;
		logic buck_dis;
		logic lamp_on;
		logic blink_run;
		logic od_level;
	} seq_reg_t;

	typedef struct packed
	{
		logic [BLINK_W-1:0] cnt;
		logic lamp;
	} blink_reg_t;

	// reset: rails off, outputs discharged, supply-ok held low
	localparam seq_reg_t SEQ_RESET = '{
		state: ST_OFF,
		pg_pull: 1'b1,
		boost_dis: 1'b1,
		buck_dis: 1'b1,
		default: '0
	};
	localparam blink_reg_t BLINK_RESET = '0;
endpackage : seq_pkg

// ===== logic/blink_if.sv
// carrier between the sequencer and its indicator blink timer
`timescale 1ns/10ps
interface blink_if;
	logic run;
	logic lamp;
	modport ctrl
	(
		output run,
		input lamp
	);
	modport timer
	(
		input run,
		output lamp
	);
endinterface : blink_if

// ===== logic/blink_timer.sv
// low battery blink timer: fixed period, fixed on fraction
`timescale 1ns/10ps
module blink_timer #(
	parameter int PERIOD_CYCLES = seq_pkg::BLINK_PERIOD_CYCLES,
	parameter int ON_CYCLES = seq_pkg::BLINK_ON_CYCLES
)(
	input wire logic core_clk, // system clock
	input wire logic srst, // synchronous reset
	blink_if.timer bl // run request and lamp phase
);
	localparam int LAST_I = PERIOD_CYCLES - 1;
	localparam int ON_I = ON_CYCLES;
	localparam logic [seq_pkg::BLINK_W-1:0] LAST =
		LAST_I[seq_pkg::BLINK_W-1:0];
	localparam logic [seq_pkg::BLINK_W-1:0] ON_END =
		ON_I[seq_pkg::BLINK_W-1:0];

	seq_pkg::blink_reg_t cur;
	seq_pkg::blink_reg_t next_cur;

	always_comb
	begin
		next_cur = cur;
		if (!bl.run)
		begin
			next_cur.cnt = '0;
		end
		else if (cur.cnt == LAST)
		begin
			next_cur.cnt = '0;
		end
		else
		begin
			next_cur.cnt = cur.cnt + 1'b1;
		end
		// lamp lit for the first quarter of each period
		next_cur.lamp = bl.run && (cur.cnt < ON_END);
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			cur <= seq_pkg::BLINK_RESET;
		else
			cur <= next_cur;
	end

	assign bl.lamp = cur.lamp;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence run_start;
		!bl.run ##1 bl.run;
	endsequence

	sequence on_phase_end;
		bl.run && cur.cnt == ON_END;
	endsequence

	blink_starts_lit_a: assert property (
		run_start |=> bl.lamp)
		else $error("blink period does not start lit");
	blink_goes_dark_a: assert property (
		on_phase_end ##1 bl.run |-> !bl.lamp)
		else $error("blink lamp stays lit past its on fraction");
endmodule : blink_timer

// ===== tb/rail_env_model.sv
// far side model: battery comparators, rail feedback, open-drain pins
`timescale 1ns/10ps
module rail_env_model #(
	parameter int RAMP = 3
)(
	input wire logic core_clk, // system clock
	input wire logic [11:0] batt_mv, // battery level in mV
	input wire logic fb_short, // force both rails below nominal
	input wire logic boost_rail_enable, // boost converter running
	input wire logic buck_rail_enable, // buck converter running
	input wire logic supply_ok_output_oe, // supply-ok pulled low
	input wire logic indicator_oe, // indicator pin pulled low
	output logic battery_start_ok, // above start level
	output logic battery_fault_low, // below fault level
	output logic battery_low_warn, // below warning level
	output logic boost_feedback_sense, // boost rail at nominal
	output logic buck_feedback_sense, // buck rail at nominal
	output logic supply_ok_wire, // pin level with pull-up
	output logic lamp_lit // indicator lamp state
);
	int boost_age = 0;
	int buck_age = 0;
	assign battery_start_ok = batt_mv > 12'h384;
	assign battery_fault_low = batt_mv < 12'h352;
	assign battery_low_warn = batt_mv < 12'h4b0;
	// rails need a few cycles to ramp before feedback reads nominal
	always @(posedge core_clk)
	begin
		boost_age <= boost_rail_enable ? boost_age + 1 : 0;
		buck_age <= buck_rail_enable ? buck_age + 1 : 0;
	end
	assign boost_feedback_sense = !fb_short && boost_age > RAMP;
	assign buck_feedback_sense = !fb_short && buck_age > RAMP;
	assign supply_ok_wire = !supply_ok_output_oe;
	assign lamp_lit = indicator_oe;
endmodule : rail_env_model

// ===== tb/testbench.sv
// self-checking bench for the dual rail sequencer
`timescale 1ns/10ps
module testbench;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic enable_pin = 1'b0;
	logic fb_short = 1'b0;
	logic [11:0] batt_mv = 12'h5dc;
	logic start_ok, fault_low, low_warn, boost_fb, buck_fb, ok_wire, lamp;
	logic boost_en, buck_en, connect, boost_dis, buck_dis;
	logic ok_out, ok_oe, ind_out, ind_oe;
	int failures = 0;
	int cmp_count = 0;
	int lit;

	always #5 core_clk = ~core_clk;

	dual_rail_sequencer_supervisor #(
		.DEGLITCH_CYCLES(4),
		.COOLOFF_CYCLES(4),
		.BLINK_PERIOD_CYCLES(40),
		.BLINK_ON_CYCLES(10)
	) i_dual_rail_sequencer_supervisor (
		.core_clk(core_clk),
		.srst(srst),
		.enable_pin(enable_pin),
		.battery_start_ok(start_ok),
		.battery_fault_low(fault_low),
		.battery_low_warn(low_warn),
		.boost_feedback_sense(boost_fb),
		.buck_feedback_sense(buck_fb),
		.boost_rail_enable(boost_en),
		.buck_rail_enable(buck_en),
		.battery_input_connect(connect),
		.boost_rail_discharge(boost_dis),
		.buck_rail_discharge(buck_dis),
		.supply_ok_output_out(ok_out),
		.supply_ok_output_oe(ok_oe),
		.indicator_out(ind_out),
		.indicator_oe(ind_oe)
	);

	rail_env_model i_rail_env_model (
		.core_clk(core_clk),
		.batt_mv(batt_mv),
		.fb_short(fb_short),
		.boost_rail_enable(boost_en),
		.buck_rail_enable(buck_en),
		.supply_ok_output_oe(ok_oe),
		.indicator_oe(ind_oe),
		.battery_start_ok(start_ok),
		.battery_fault_low(fault_low),
		.battery_low_warn(low_warn),
		.boost_feedback_sense(boost_fb),
		.buck_feedback_sense(buck_fb),
		.supply_ok_wire(ok_wire),
		.lamp_lit(lamp)
	);

	task automatic wrap_up();
		if (failures == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up

	task automatic check_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_bit

	task automatic check_num(input int got, input int exp);
		cmp_count++;
		if (got != exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_num

	task automatic cycles(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cycles

	function automatic logic pick(input int idx);
		case (idx)
			0: return boost_en;
			1: return buck_en;
			2: return ok_oe;
			default: return ind_oe;
		endcase
	endfunction : pick

	// bounded wait; a run-out is a mismatch and ends the run
	task automatic wait_bit(input int idx, input logic val, input int lim);
		int n;
		n = 0;
		while (pick(idx) !== val && n < lim)
		begin
			@(negedge core_clk);
			n++;
		end
		check_bit(pick(idx), val);
		if (pick(idx) !== val)
			wrap_up();
	endtask : wait_bit

	task automatic count_lit(input int n);
		lit = 0;
		repeat (n)
		begin
			@(negedge core_clk);
			if (lamp === 1'b1)
				lit++;
		end
	endtask : count_lit

	task automatic sc_reset();
		cycles(2);
		check_bit(boost_en, 1'b0);
		check_bit(boost_dis, 1'b1);
		check_bit(ok_oe, 1'b1);
		check_bit(ok_out, 1'b0);
		check_bit(ind_out, 1'b0);
	endtask : sc_reset

	task automatic sc_start();
		enable_pin = 1'b1;
		batt_mv = 12'h370;
		cycles(30);
		check_bit(boost_en, 1'b0);
		batt_mv = 12'h5dc;
		wait_bit(0, 1'b1, 20);
		check_bit(buck_en, 1'b0);
		wait_bit(1, 1'b1, 20);
		check_bit(connect, 1'b1);
		wait_bit(2, 1'b0, 20);
		check_bit(ok_wire, 1'b1);
		count_lit(50);
		check_num(lit, 50);
	endtask : sc_start

	task automatic sc_enable_low();
		enable_pin = 1'b0;
		cycles(4);
		check_bit(boost_en, 1'b0);
		check_bit(buck_en, 1'b0);
		check_bit(connect, 1'b0);
		check_bit(boost_dis, 1'b1);
		check_bit(buck_dis, 1'b1);
		check_bit(ok_oe, 1'b1);
		check_bit(ind_oe, 1'b0);
		enable_pin = 1'b1;
		wait_bit(2, 1'b0, 40);
	endtask : sc_enable_low

	task automatic sc_glitch();
		fb_short = 1'b1;
		cycles(2);
		fb_short = 1'b0;
		cycles(12);
		check_bit(ok_oe, 1'b0);
		fb_short = 1'b1;
		wait_bit(2, 1'b1, 12);
		check_bit(boost_en, 1'b0);
		check_bit(boost_dis, 1'b1);
		check_bit(buck_dis, 1'b1);
		fb_short = 1'b0;
		wait_bit(2, 1'b0, 40);
	endtask : sc_glitch

	task automatic sc_blink();
		batt_mv = 12'h3e8;
		cycles(10);
		count_lit(80);
		check_num(lit, 20);
	endtask : sc_blink

	task automatic sc_fault();
		batt_mv = 12'h320;
		cycles(40);
		batt_mv = 12'h3e8;
		cycles(8);
		batt_mv = 12'h320;
		cycles(20);
		count_lit(40);
		check_num(lit, 10);
		cycles(100);
		count_lit(40);
		check_num(lit, 0);
		check_bit(boost_dis, 1'b1);
		check_bit(buck_dis, 1'b1);
		batt_mv = 12'h5dc;
		cycles(20);
		check_bit(boost_en, 1'b0);
		check_bit(buck_en, 1'b0);
		check_bit(connect, 1'b0);
		enable_pin = 1'b0;
		cycles(4);
		enable_pin = 1'b1;
		wait_bit(2, 1'b0, 40);
	endtask : sc_fault

	initial
	begin
		cycles(16);
		srst = 1'b0;
		sc_reset();
		sc_start();
		sc_enable_low();
		sc_glitch();
		sc_blink();
		sc_fault();
		wrap_up();
	end
endmodule : testbench
